// ==== hdl/pcc_regs.sv ====
// Capability-area configuration registers of the 1394 link controller
module pcc_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire pcc_pkg::pcc_req_t cfg_req,
    input wire logic [31:0] vendor_control_word,
    output pcc_pkg::pcc_rsp_t cfg_rsp,
    output logic [7:0] irq_routing_line
);

    // ----------------------------------------------------------------
    // Overview
    // ----------------------------------------------------------------
    // Every access is taken on an enabled edge and answered on the
    // next enabled edge with a one-cycle acknowledge. Reads return a
    // whole dword; writes are acknowledged with zero data.
    // Only the interrupt line byte holds state. All other bytes are
    // constants or follow the visibility bit, which comes from the
    // vendor control word on this clock and so needs no synchroniser.
    // The head pointer and capability code track that bit live, so
    // whatever the EEPROM loads into it also sets their reset value.
    // Hazard: clearing the bit while software walks the list makes
    // the head vanish on its next read; nothing is latched here.
    // The power-management capability and control/status bytes from
    // 46h up live outside this bank and read zero here.
    // Clock enable low freezes the answer as well as the line byte.

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    pcc_pkg::pcc_state_t st_q; // Registered bank state
    pcc_pkg::pcc_state_t st_d; // Next bank state
    logic pm_list_visible_enable; // Capability list shown
    logic [5:0] dw; // Dword number of the access
    logic [7:0] head_val; // Head pointer byte
    logic [7:0] cap_val; // Capability code byte

    // Visibility bit from the vendor control word
    assign pm_list_visible_enable =
        vendor_control_word[pcc_pkg::VIS_BIT_POS];

    // Dword number of the access
    assign dw = cfg_req.addr[7:2];

    // Head pointer follows the enable bit, so its reset value
    // follows whatever the EEPROM loaded into that bit
    always_comb begin
        if (pm_list_visible_enable) begin
            head_val = pcc_pkg::PM_CAP_OFS;
        end else begin
            head_val = 8'h00;
        end
    end

    // Capability code hidden along with the list
    always_comb begin
        if (pm_list_visible_enable) begin
            cap_val = pcc_pkg::PM_CAP_CODE;
        end else begin
            cap_val = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Address bits 1:0 are ignored: every access is a whole dword.
    // Answer fields default to zero so only a taken access acks.
    always_comb begin
        st_d = st_q;
        st_d.rsp.ack = 1'b0;
        st_d.rsp.rdata = 32'h0000_0000;
        if (cfg_req.valid) begin
            // Every access is answered one cycle later
            st_d.rsp.ack = 1'b1;
            if (cfg_req.write) begin
                // Only the line byte takes write data
                if (dw == pcc_pkg::IRQ_LINE_OFS[7:2]
                    && cfg_req.be[0]) begin
                    st_d.irq_line = cfg_req.wdata[7:0];
                end
                // All other bytes ignore writes
            end else if (dw == pcc_pkg::CAP_HEAD_OFS[7:2]) begin
                // Head pointer, upper reserved bytes read zero
                st_d.rsp.rdata = {24'h00_0000, head_val};
            end else if (dw == pcc_pkg::IRQ_LINE_OFS[7:2]) begin
                // Line, pin, grant, latency in byte order
                st_d.rsp.rdata = {pcc_pkg::LATENCY_VAL,
                                  pcc_pkg::GRANT_VAL,
                                  pcc_pkg::IRQ_PIN_VAL,
                                  st_q.irq_line};
            end else if (dw == pcc_pkg::PM_CAP_OFS[7:2]) begin
                // Capability code and terminating next pointer
                st_d.rsp.rdata = {16'h0000,
                                  pcc_pkg::PM_NEXT_VAL,
                                  cap_val};
            end else if (dw == pcc_pkg::PM_CSR_OFS[7:2]) begin
                // Control/status dword belongs to the power-management
                // block outside this bank; it reads zero here
                st_d.rsp.rdata = 32'h0000_0000;
            end else begin
                // Reserved and other offsets read zero
                st_d.rsp.rdata = 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // The whole bank state is one struct: the line byte and the
    // registered answer. Registering the answer keeps every output
    // straight from a flip-flop, at the cost of a cycle of latency.
    // Synchronous reset; clock enable freezes everything
    // Reset takes effect even while the enable is low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q.irq_line <= pcc_pkg::IRQ_LINE_RST;
            st_q.rsp.ack <= 1'b0;
            st_q.rsp.rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign cfg_rsp = st_q.rsp;
    assign irq_routing_line = st_q.irq_line;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // All checks run on sys_clk; all but the line reset check stand down during reset.
    // Read checks look one edge back: a read taken there on an
    // enabled edge, out of reset, must show its data now. The
    // answer does not move until the next enabled edge.

    // Every access answered one cycle later
    ack_timing_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cfg_req.valid && clk_en) |=> cfg_rsp.ack)
        else $error("access not acknowledged");

    // No answer without a request
    ack_cause_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cfg_rsp.ack && $past(clk_en)) |-> $past(cfg_req.valid))
        else $error("spurious acknowledge");

    // Head pointer value against visibility
    head_value_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h0d) |->
        cfg_rsp.rdata == ($past(pm_list_visible_enable)
                          ? 32'h0000_0044 : 32'h0000_0000))
        else $error("head pointer value wrong");

    // Line reset value seen just after reset
    line_reset_a: assert property (
        @(posedge sys_clk)
        $past(rst) |-> irq_routing_line == 8'hff)
        else $error("line byte not reset to ff");

    // Line byte keeps a written value
    line_write_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clk_en && cfg_req.valid && cfg_req.write
         && dw == 6'h0f && cfg_req.be[0]) |=>
        irq_routing_line == $past(cfg_req.wdata[7:0]))
        else $error("line byte write lost");

    // Line byte changes only by a write
    line_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !(cfg_req.valid && cfg_req.write && dw == 6'h0f)
        |=> $stable(irq_routing_line))
        else $error("line byte changed without write");

    // Pin, grant and latency constant
    pin_grant_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h0f) |->
        cfg_rsp.rdata[31:8] == 24'h00_0001)
        else $error("pin, grant or latency wrong");

    // Capability code and next pointer
    cap_entry_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h11) |->
        cfg_rsp.rdata == ($past(pm_list_visible_enable)
                          ? 32'h0000_0001 : 32'h0000_0000))
        else $error("capability entry wrong");

    // Reserved dword 40h reads zero
    rsvd_zero_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h10) |->
        cfg_rsp.rdata == 32'h0000_0000)
        else $error("reserved offset not zero");

    // Enable low freezes the answer and the line byte
    freeze_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !clk_en |=> ($stable(cfg_rsp) && $stable(irq_routing_line)))
        else $error("state moved while enable low");

    // Read data is zero whenever no answer stands
    idle_zero_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !cfg_rsp.ack |-> cfg_rsp.rdata == 32'h0000_0000)
        else $error("read data without answer");

    // A write answer carries no data
    write_ack_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && $past(cfg_req.write)
         && $past(clk_en) && !$past(rst)) |->
        (cfg_rsp.ack && cfg_rsp.rdata == 32'h0000_0000))
        else $error("write answer not empty");

    // Line byte ignores a write without its byte enable
    line_mask_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clk_en && cfg_req.valid && cfg_req.write
         && dw == 6'h0f && !cfg_req.be[0]) |=>
        $stable(irq_routing_line))
        else $error("line byte took masked write");

    // Line read returns the stored byte
    line_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h0f) |->
        cfg_rsp.rdata[7:0] == $past(irq_routing_line))
        else $error("line byte read wrong");

    // Pin byte names the first request pin
    pin_byte_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h0f) |->
        cfg_rsp.rdata[15:8] == 8'h01)
        else $error("pin byte wrong");

    // Grant byte reads zero
    grant_byte_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h0f) |->
        cfg_rsp.rdata[23:16] == 8'h00)
        else $error("grant byte wrong");

    // Latency byte reads zero
    latency_byte_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h0f) |->
        cfg_rsp.rdata[31:24] == 8'h00)
        else $error("latency byte wrong");

    // Next pointer byte always zero
    next_ptr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h11) |->
        cfg_rsp.rdata[15:8] == 8'h00)
        else $error("next pointer not zero");

    // Reserved dword 38h reads zero
    rsvd_low_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h0e) |->
        cfg_rsp.rdata == 32'h0000_0000)
        else $error("reserved dword 38h not zero");

    // Control/status dword is left to the outside block
    csr_zero_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ($past(cfg_req.valid) && !$past(cfg_req.write)
         && $past(clk_en) && !$past(rst)
         && $past(dw) == 6'h12) |->
        cfg_rsp.rdata == 32'h0000_0000)
        else $error("control dword not zero");

    // An answer lasts one enabled cycle unless a new access follows
    ack_drop_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cfg_rsp.ack && clk_en && !cfg_req.valid) |=> !cfg_rsp.ack)
        else $error("acknowledge held too long");

endmodule // pcc_regs

// ==== hdl/pcc_pkg.sv ====
// Constants and types for the capability-area configuration registers
// Functional notes
// - Head pointer reads 44h when visible, else 0
// - Head pointer reset follows EEPROM-loaded enable bit
// - Power-management block sits at 44h and 48h
// - Interrupt line byte read/write, resets to FFh
// - Interrupt pin byte read-only, returns 01h
// - Minimum grant read-only, returns 00h
// - Maximum latency read-only, returns 00h
// - Capability code 01h when visible, else 0
// - Next capability pointer always reads 00h
package pcc_pkg;

    // ----------------------------------------------------------------
    // Configuration offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CAP_HEAD_OFS = 8'h34;
    localparam logic [7:0] IRQ_LINE_OFS = 8'h3c;
    localparam logic [7:0] IRQ_PIN_OFS = 8'h3d;
    localparam logic [7:0] GRANT_OFS = 8'h3e;
    localparam logic [7:0] LATENCY_OFS = 8'h3f;
    localparam logic [7:0] PM_CAP_OFS = 8'h44;
    localparam logic [7:0] PM_NEXT_OFS = 8'h45;
    localparam logic [7:0] PM_CSR_OFS = 8'h48;

    // ----------------------------------------------------------------
    // Field values and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] IRQ_LINE_RST = 8'hff;
    localparam logic [7:0] IRQ_PIN_VAL = 8'h01;
    localparam logic [7:0] GRANT_VAL = 8'h00;
    localparam logic [7:0] LATENCY_VAL = 8'h00;
    localparam logic [7:0] PM_CAP_CODE = 8'h01;
    localparam logic [7:0] PM_NEXT_VAL = 8'h00;
    localparam int VIS_BIT_POS = 20;

    // Grant field unit, in ns
    localparam int GRANT_UNIT_NS = 250;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // One configuration access
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcc_req_t;

    // One configuration answer
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } pcc_rsp_t;

    // All state of the register bank
    typedef struct packed {
        logic [7:0] irq_line;
        pcc_rsp_t rsp;
    } pcc_state_t;

endpackage : pcc_pkg

// ==== test/pcc_host.sv ====
// Host bridge model issuing configuration accesses
module pcc_host (
    input wire logic sys_clk,
    output pcc_pkg::pcc_req_t cfg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial cfg_req = '0;
    // One access, held from a falling edge to the next
    task automatic access(input logic wr, input logic [7:0] a,
            input logic [3:0] be, input logic [31:0] wd);
        cfg_req <= {1'b1, wr, a, be, wd};
        @(negedge sys_clk);
    endtask
    // Release the request, data lines inverted
    task automatic idle();
        cfg_req <= {1'b0, ~cfg_req[44:0]};
        @(negedge sys_clk);
    endtask
endmodule // pcc_host

// ==== test/pcc_regs_tb_top.sv ====
// Self-checking bench for the capability-area registers
module pcc_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1; // Running except during the stall test
    logic [31:0] vendor_control_word = 32'h00100000; // List visible
    pcc_pkg::pcc_req_t cfg_req;
    pcc_pkg::pcc_rsp_t cfg_rsp;
    logic [7:0] irq_routing_line;
    logic [31:0] exp_q[$]; // Expected read data, oldest first
    logic [7:0] line; // Expected interrupt line byte
    logic [31:0] d;
    logic [3:0] b;
    logic [7:0] ra;
    logic v;
    logic en_at_edge = 1'b1; // Enable seen at the last rising edge
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 32'hd267e166;
    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;
    pcc_host host (.sys_clk(sys_clk), .cfg_req(cfg_req));
    pcc_regs DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .cfg_req(cfg_req), .vendor_control_word(vendor_control_word),
        .cfg_rsp(cfg_rsp), .irq_routing_line(irq_routing_line));
    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Note expectation, then issue the access
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 4'h0, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be);
        exp_q.push_back(32'h0); // Write acks carry zero
        host.access(1'b1, a, be, d);
    endtask
    // Enable at each rising edge: a frozen ack is not a new answer
    always @(posedge sys_clk) en_at_edge <= clk_en;
    // Answer watcher: oldest note against each fresh ack
    always @(negedge sys_clk) begin
        if (cfg_rsp.ack === 1'b1 && en_at_edge) begin
            if (exp_q.size() == 0) chk("spare ack", 32'h0, 32'h1);
            else chk("rdata", exp_q.pop_front(), cfg_rsp.rdata);
        end
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        line = 8'hff;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        rd(8'h34, 32'h44);
        rd(8'h3c, {8'h00, 8'h00, 8'h01, line});
        for (int t = 0; t < 10; t++) begin
            v = t[0];
            vendor_control_word = ($random(seed) & ~32'h100000) | (v << 20);
            rd(8'h34, v ? 32'h44 : 32'h0);
            rd(8'h44, v ? 32'h01 : 32'h0);
            d = $random(seed);
            b = 4'($random(seed));
            wr(8'h3c, b);
            if (b[0]) line = d[7:0];
            chk("irq line", {24'h0, line}, {24'h0, irq_routing_line});
            rd(8'h3c, {8'h00, 8'h00, 8'h01, line});
            // Writes to read-only and reserved places change nothing
            ra = (t % 3 == 0) ? 8'h34 : (t % 3 == 1) ? 8'h38 : 8'h40;
            wr(ra, 4'hf);
            wr(8'h44, 4'hf);
            rd(8'h38, 32'h0);
            rd(8'h40, 32'h0);
            rd(8'h34, v ? 32'h44 : 32'h0);
            rd(8'h44, v ? 32'h01 : 32'h0);
            rd(8'h48, 32'h0);
            $display("test %0d done", t);
        end
        // Enable low: a held write is not taken, the answer freezes
        clk_en = 1'b0;
        host.access(1'b1, 8'h3c, 4'h1, {24'h0, ~line});
        chk("stall line", {24'h0, line}, {24'h0, irq_routing_line});
        clk_en = 1'b1;
        host.idle();
        $display("test stall done");
        // Mid-run reset with the list hidden by the EEPROM setting
        vendor_control_word = $random(seed) & ~32'h100000;
        rst = 1'b1;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        line = 8'hff;
        chk("line reset", {24'h0, line}, {24'h0, irq_routing_line});
        rd(8'h34, 32'h0);
        rd(8'h44, 32'h0);
        rd(8'h3c, {8'h00, 8'h00, 8'h01, line});
        host.idle();
        $display("test reset done");
        repeat (4) @(negedge sys_clk);
        chk("queue empty", 32'h0, exp_q.size());
        results();
    end
endmodule // pcc_regs_tb_top
